//--- pkg/bridge_mode_pkg.sv
package bridge_mode_pkg;

	localparam int unsigned CLK_HZ        = 40_000_000;
	// Sleep-entry interval in microseconds (1 ms)
	localparam int unsigned SLEEP_US      = 1000;
	localparam int unsigned SLEEP_CYCLES  = (SLEEP_US * (CLK_HZ / 1_000_000));
	// Wake interval in microseconds; nothing prints it, so a plain default
	localparam int unsigned WAKE_US       = 100;
	localparam int unsigned WAKE_CYCLES   = (WAKE_US * (CLK_HZ / 1_000_000));
	localparam int unsigned CNT_W         = 16;

	typedef enum logic [1:0] {
		DRV_COAST,
		DRV_REVERSE,
		DRV_FORWARD,
		DRV_BRAKE
	} drive_e;

	// One half-bridge output: drive level and output enable
	typedef struct packed {
		logic level;
		logic enable;
	} half_bridge_s;

	typedef struct packed {
		logic supply_low_lockout;
		logic overcurrent;
		logic overtemp_shutdown;
	} fault_in_s;

	typedef struct packed {
		logic sleep;
		logic active;
		logic fault;
		logic overcurrent_latch;
		logic overtemp_shutdown;
		logic circuits_on;
	} mode_status_s;

endpackage

//--- rtl/input_sync.sv
`timescale 1ns/1ps
module input_sync
	import bridge_mode_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_async,
	output logic      o_level
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Change accepted once second and third stage agree
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_level <= 1'b0;
		end else if (s2_reg == s3_reg) begin
			o_level <= s3_reg;
		end
	end

endmodule

//--- rtl/bridge_mode_ctrl.sv
// Summary of operation
// [RULE1] Both inputs low for interval: sleep
// [RULE2] Sleep: outputs high-Z, circuits off
// [RULE3] Power-up with inputs low: immediate sleep
// [RULE4] Wake after input high beyond interval
// [RULE5] Any fault: fault mode, bridge off
// [RULE6] Fault behaviour depends on fault type
// [RULE7] Recovery met: resume active driving
// [RULE8] Overcurrent latched until sleep or power
// [RULE9] Host may ramp PWM at startup
// [RULE10] Input pair selects coast/reverse/forward/brake
// [RULE11] Supply low: everything off, logic reset
// [RULE12] Overtemp clears itself below hysteresis
// [RULE13] Interval counters restart on glitches
`timescale 1ns/1ps
module bridge_mode_ctrl
	import bridge_mode_pkg::*;
(
	input  wire logic   i_clk,
	input  wire logic   i_rst_n,
	input  wire logic   i_drive_input_a,
	input  wire logic   i_drive_input_b,
	input  wire logic   i_supply_low_lockout,
	input  wire logic   i_overcurrent,
	input  wire logic   i_overtemp_shutdown,
	output half_bridge_s o_bridge_output_a,
	output half_bridge_s o_bridge_output_b,
	output mode_status_s o_status
);

	typedef enum logic [2:0] {
		ST_POWERUP,
		ST_SLEEP,
		ST_WAKING,
		ST_ACTIVE,
		ST_FAULT
	} mode_e;

	localparam logic [CNT_W-1:0] SLEEP_LAST = CNT_W'(SLEEP_CYCLES - 1);
	localparam logic [CNT_W-1:0] WAKE_LAST  = CNT_W'(WAKE_CYCLES - 1);

	logic      in_a;
	logic      in_b;
	fault_in_s flt;

	input_sync u_sync_a (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async (i_drive_input_a),
		.o_level (in_a)
	);
	input_sync u_sync_b (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async (i_drive_input_b),
		.o_level (in_b)
	);
	input_sync u_sync_uv (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async (i_supply_low_lockout),
		.o_level (flt.supply_low_lockout)
	);
	input_sync u_sync_oc (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async (i_overcurrent),
		.o_level (flt.overcurrent)
	);
	input_sync u_sync_ot (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_async (i_overtemp_shutdown),
		.o_level (flt.overtemp_shutdown)
	);

	mode_e           mode_reg;
	mode_e           mode_next;
	logic [CNT_W-1:0] sleep_cnt_reg;
	logic [CNT_W-1:0] wake_cnt_reg;
	logic [2:0]      settle_reg;
	logic            oc_latch_reg;
	logic            ot_reg;
	logic            both_low;
	logic            sleep_done;
	logic            wake_done;
	drive_e          drive;

	assign both_low   = !in_a && !in_b;
	assign sleep_done = both_low && (sleep_cnt_reg == SLEEP_LAST);
	assign wake_done  = !both_low && (wake_cnt_reg == WAKE_LAST);

	// [RULE10] input pair decode
	always_comb begin
		case ({in_a, in_b})
			2'b01:   drive = DRV_REVERSE;
			2'b10:   drive = DRV_FORWARD;
			2'b11:   drive = DRV_BRAKE;
			default: drive = DRV_COAST;
		endcase
	end

	// Synchronisers settle before the power-up decision
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			settle_reg <= 3'h0;
		end else if (flt.supply_low_lockout) begin
			settle_reg <= 3'h0;
		end else if (settle_reg != 3'h7) begin
			settle_reg <= settle_reg + 3'h1;
		end
	end

	// [RULE1] [RULE13] sleep-entry counter restarts on any high input
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sleep_cnt_reg <= '0;
		end else if (!both_low || mode_reg != ST_ACTIVE) begin
			sleep_cnt_reg <= '0;
		end else if (!sleep_done) begin
			sleep_cnt_reg <= sleep_cnt_reg + CNT_W'(1);
		end
	end

	// [RULE4] [RULE13] wake counter restarts when inputs fall back low
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wake_cnt_reg <= '0;
		end else if (both_low || mode_reg != ST_WAKING) begin
			wake_cnt_reg <= '0;
		end else if (!wake_done) begin
			wake_cnt_reg <= wake_cnt_reg + CNT_W'(1);
		end
	end

	// [RULE8] overcurrent latch, cleared only by sleep or supply loss
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			oc_latch_reg <= 1'b0;
		end else if (flt.supply_low_lockout) begin
			oc_latch_reg <= 1'b0;
		end else if (flt.overcurrent && mode_reg != ST_SLEEP) begin
			oc_latch_reg <= 1'b1;
		end else if (mode_reg == ST_SLEEP) begin
			oc_latch_reg <= 1'b0;
		end
	end

	// [RULE12] overtemp follows the hysteresis comparator
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ot_reg <= 1'b0;
		end else if (flt.supply_low_lockout) begin
			ot_reg <= 1'b0;
		end else begin
			ot_reg <= flt.overtemp_shutdown;
		end
	end

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			ST_POWERUP: begin
				// [RULE3] straight to sleep when inputs low
				if (settle_reg == 3'h7) begin
					mode_next = both_low ? ST_SLEEP : ST_WAKING;
				end
			end
			ST_SLEEP: begin
				if (!both_low) begin
					mode_next = ST_WAKING;
				end
			end
			ST_WAKING: begin
				// [RULE4] active only after wake interval
				if (both_low) begin
					mode_next = ST_SLEEP;
				end else if (wake_done) begin
					mode_next = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				// [RULE5] any fault leaves active
				if (oc_latch_reg || flt.overcurrent || ot_reg) begin
					mode_next = ST_FAULT;
				end else if (sleep_done) begin
					mode_next = ST_SLEEP;
				end
			end
			ST_FAULT: begin
				// [RULE7] [RULE8] overcurrent recovery needs sleep with current low
				if (oc_latch_reg) begin
					if (sleep_done || (both_low && !flt.overcurrent)) begin
						mode_next = ST_SLEEP;
					end
				end else if (!ot_reg && !flt.overcurrent) begin
					mode_next = ST_ACTIVE;
				end
			end
			default: mode_next = ST_POWERUP;
		endcase
	end

	// [RULE11] supply low resets all mode logic
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_reg <= ST_POWERUP;
		end else if (flt.supply_low_lockout) begin
			mode_reg <= ST_POWERUP;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// [RULE2] [RULE5] bridge driven only in active mode
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bridge_output_a <= '0;
			o_bridge_output_b <= '0;
		end else if (mode_next != ST_ACTIVE || flt.supply_low_lockout) begin
			o_bridge_output_a <= '0;
			o_bridge_output_b <= '0;
		end else begin
			case (drive)
				DRV_REVERSE: begin
					o_bridge_output_a <= '{level: 1'b0, enable: 1'b1};
					o_bridge_output_b <= '{level: 1'b1, enable: 1'b1};
				end
				DRV_FORWARD: begin
					o_bridge_output_a <= '{level: 1'b1, enable: 1'b1};
					o_bridge_output_b <= '{level: 1'b0, enable: 1'b1};
				end
				DRV_BRAKE: begin
					o_bridge_output_a <= '{level: 1'b0, enable: 1'b1};
					o_bridge_output_b <= '{level: 1'b0, enable: 1'b1};
				end
				default: begin
					o_bridge_output_a <= '0;
					o_bridge_output_b <= '0;
				end
			endcase
		end
	end

	// [RULE6] circuits stay on in overcurrent and overtemp faults
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_status <= '0;
		end else if (flt.supply_low_lockout) begin
			// [RULE11] supply low clears all status
			o_status <= '0;
		end else begin
			o_status.sleep             <= (mode_next == ST_SLEEP);
			o_status.active            <= (mode_next == ST_ACTIVE);
			o_status.fault             <= (mode_next == ST_FAULT);
			o_status.overcurrent_latch <= oc_latch_reg;
			o_status.overtemp_shutdown <= ot_reg;
			o_status.circuits_on       <= !flt.supply_low_lockout
				&& mode_next != ST_SLEEP && mode_next != ST_POWERUP;
		end
	end

endmodule

//--- test/bridge_mode_assertions.sv
`timescale 1ns/1ps
module bridge_mode_assertions
	import bridge_mode_pkg::*;
(
	input wire logic   i_clk,
	input wire logic   i_rst_n,
	input wire logic   i_supply_low_lockout,
	input wire logic   i_overcurrent,
	input half_bridge_s o_bridge_output_a,
	input half_bridge_s o_bridge_output_b,
	input mode_status_s o_status
);
	logic en;
	logic both;
	assign en = o_bridge_output_a.enable || o_bridge_output_b.enable;
	assign both = o_bridge_output_a.enable && o_bridge_output_b.enable;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_SLEEP_Z: assert property (o_status.sleep |-> !en && !o_status.circuits_on)
		else $error("Sleep with drive");
	AST_FAULT_Z: assert property (o_status.fault |-> !en)
		else $error("Fault with drive");
	AST_OC_SET: assert property ($rose(i_overcurrent) && o_status.active |-> ##[1:8] o_status.fault)
		else $error("No overcurrent fault");
	AST_OC_FLT: assert property ($rose(o_status.overcurrent_latch) |-> o_status.fault)
		else $error("Latch without fault");
	AST_OC_CLR: assert property ($fell(o_status.overcurrent_latch) |-> !o_status.circuits_on)
		else $error("Latch cleared awake");
	AST_OT_FLT: assert property (o_status.overtemp_shutdown |-> o_status.fault && o_status.circuits_on)
		else $error("Overtemp mode wrong");
	AST_EN_ACT: assert property (en |-> o_status.active)
		else $error("Drive outside active");
	AST_PAIR: assert property (en |-> both && !(o_bridge_output_a.level && o_bridge_output_b.level))
		else $error("Bad output pair");
	AST_SUPPLY: assert property (i_supply_low_lockout [*8] |-> !en && !o_status.circuits_on)
		else $error("Supply low not off");
	cover property ($rose(o_status.sleep));
	cover property ($rose(o_status.fault));
	cover property ($rose(o_status.active));
endmodule
bind bridge_mode_ctrl bridge_mode_assertions bridge_mode_assertions_i (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_supply_low_lockout(i_supply_low_lockout),
	.i_overcurrent(i_overcurrent), .o_bridge_output_a(o_bridge_output_a),
	.o_bridge_output_b(o_bridge_output_b), .o_status(o_status));

//--- test/host_model.sv
`timescale 1ns/1ps
module host_model (
	input  wire logic       i_clk,
	input  wire logic [1:0] i_cmd,
	input  wire logic       i_ramp,
	output logic            o_a,
	output logic            o_b
);
	logic [11:0] cnt_reg = 12'h000;
	always @(posedge i_clk) begin
		cnt_reg <= cnt_reg + 12'h001;
	end
	assign {o_a, o_b} = (i_ramp && cnt_reg[3:0] > cnt_reg[11:8]) ? 2'h3 : i_cmd;
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
	import bridge_mode_pkg::*;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic [1:0]   cmd = 2'h2;
	logic         ramp = 1'b0;
	logic         sl = 1'b0;
	logic         oc = 1'b0;
	logic         ot = 1'b0;
	logic         da;
	logic         db;
	half_bridge_s oa;
	half_bridge_s ob;
	mode_status_s st;
	int           n_fail = 0;
	int           checks_done = 0;
	int           n;
	int           r;
	logic [3:0]   tbl [4] = '{4'h0, 4'h7, 4'hD, 4'h5};
	always #12.5 clk = ~clk;
	bridge_mode_ctrl bridge_mode_ctrl_i (.i_clk(clk), .i_rst_n(rst_n), .i_drive_input_a(da),
		.i_drive_input_b(db), .i_supply_low_lockout(sl), .i_overcurrent(oc),
		.i_overtemp_shutdown(ot), .o_bridge_output_a(oa), .o_bridge_output_b(ob), .o_status(st));
	host_model host_model_i (.i_clk(clk), .i_cmd(cmd), .i_ramp(ramp), .o_a(da), .o_b(db));
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic set(input logic [1:0] c, input int k);
		@(posedge clk) cmd <= c;
		cyc(k);
	endtask
	task automatic wt(input logic s, output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while ((s ? st.sleep : st.active) !== 1'b1 && c < 50000);
	endtask
	task automatic conclude;
		$display("Checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		// About 82k cycles of tests, so allow 92k before giving up
		#2300000;
		n_fail++;
		conclude();
	end
	initial begin
		r = $urandom(88014);
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wt(0, n);
		chk("wake", 8'(n >= 4000 && n <= 4030), 8'h01);
		chk("st", 8'(st), 8'h11);
		r = $urandom % 4;
		for (int i = 0; i < 4; i++) begin
			set(2'((i + r) % 4), 8);
			chk("br", {4'h0, oa, ob}, {4'h0, tbl[(i + r) % 4]});
		end
		set(2'h0, 30000);
		set(2'h2, 20);
		set(2'h0, 0);
		wt(1, n);
		chk("sleep", 8'(n >= SLEEP_CYCLES && n <= SLEEP_CYCLES + 20), 8'h01);
		chk("st", {st, oa.enable, ob.enable}, 8'h80);
		set(2'h1, 100);
		set(2'h0, 10);
		chk("st", 8'(st), 8'h20);
		set(2'h1, 0);
		wt(0, n);
		chk("wake", 8'(n >= 4000 && n <= 4020), 8'h01);
		@(posedge clk) oc <= 1'b1;
		cyc(10);
		chk("st", {st, oa.enable, ob.enable}, 8'h34);
		@(posedge clk) oc <= 1'b0;
		cyc(10);
		chk("st", 8'(st), 8'h0D);
		set(2'h0, 0);
		wt(1, n);
		chk("sleep", 8'(n < 30), 8'h01);
		// Latch clears one edge into sleep, status flag follows one edge later
		cyc(4);
		chk("st", 8'(st), 8'h20);
		@(posedge clk) ramp <= 1'b1;
		set(2'h2, 0);
		wt(0, n);
		chk("wake", 8'(n >= 4000 && n <= 4100), 8'h01);
		@(posedge clk) ramp <= 1'b0;
		cyc(10);
		chk("br", {4'h0, oa, ob}, {4'h0, tbl[2]});
		@(posedge clk) ot <= 1'b1;
		cyc(10);
		chk("st", 8'(st), 8'h0B);
		@(posedge clk) ot <= 1'b0;
		cyc(10);
		chk("st", {st, oa.enable, ob.enable}, 8'h47);
		set(2'h0, 0);
		@(posedge clk) sl <= 1'b1;
		cyc(10);
		chk("st", {st, oa.enable, ob.enable}, 8'h00);
		@(posedge clk) sl <= 1'b0;
		wt(1, n);
		chk("pwr", 8'(n < 30), 8'h01);
		conclude();
	end
endmodule
